// ===== core/pll_lock_params.svh
// Offsets, field positions, reset values and timing figures of the lock-indication block.
// Assumes word-indexed register addressing; included by pll_lock_detect_logic.
`ifndef PLL_LOCK_PARAMS_SVH
`define PLL_LOCK_PARAMS_SVH

// Register indices
`define REG_FB_A_COUNT 10'h013
`define REG_FB_B_LOW 10'h014
`define REG_FB_B_HIGH 10'h015
`define REG_PRESCALER 10'h016
`define REG_STATUS_ABP 10'h017
`define REG_LOCK_CFG 10'h018
`define REG_DIV_DELAY 10'h019
`define REG_LP_PIN_CTRL 10'h01A
`define REG_MONPIN_CTRL 10'h01B
`define REG_HOLDOVER_CTRL 10'h01D
`define REG_OUT_GATE_LO 10'h0FC
`define REG_OUT_GATE_HI 10'h0FD
`define REG_CLK_IN_CTRL 10'h1E0
`define REG_LOCK_STATUS 10'h1F0
`define REG_RUN_COUNT 10'h1F1
`define REG_FB_N_0 10'h1F2
`define REG_FB_N_1 10'h1F3
`define REG_FB_N_2 10'h1F4

// Field positions
`define F_CNT_SEL_HI 6
`define F_CNT_SEL_LO 5
`define F_WINDOW 4
`define F_DLI_DISABLE 3
`define F_ABP_HI 1
`define F_STATUS_SEL_LO 2
`define F_REF_DELAY_LO 3
`define F_LP_CMP_EN 3

// Reset values
`define RST_REG8 8'h00
`define RST_B_LOW 8'h03

// Pin selection codes
`define LP_CODE_DLI 6'h01
`define LP_CODE_ALO_N 6'h02
`define LP_CODE_ALO_P 6'h03
`define LP_CODE_CHLK 6'h04
`define PIN_SEL_DLI 6'h01
`define PIN_SEL_LP_CMP 6'h02

// Prescaler codes at or above this value are dual-modulus
`define PRE_DM_FIRST 3'h3

// Lock cycle counts per select code
`define LOCK_CYCLES_00 8'h05
`define LOCK_CYCLES_01 8'h10
`define LOCK_CYCLES_10 8'h40
`define LOCK_CYCLES_11 8'hFF

// Window thresholds in ps of edge difference
`define LOCK_THR_HIGH_PS 16'h0DAC
`define UNLOCK_THR_HIGH_PS 16'h1B58
`define LOCK_THR_LOW_PS 16'h0226
`define UNLOCK_THR_LOW_PS 16'h03E8
`define ABP_STEP_PS 16'h00C8
`define DELAY_RANGE_PS 1000

`endif

// ===== core/pll_lock_pkg.sv
// Types shared by the lock-indication modules.
// Assumes nothing of its surroundings.
package pll_lock_pkg;
	typedef enum logic [1:0] {LOCK_HUNT, LOCK_HELD} lock_state_t;
	typedef enum logic [2:0] {LP_OFF, LP_DLI, LP_ALO_N, LP_ALO_P, LP_CHLK} lp_mode_t;
	typedef enum logic [1:0] {CLK_IN_DIST, CLK_IN_EXT_VCO, CLK_IN_ZERO_DELAY} clk_in_mode_t;
endpackage

// ===== core/lock_detect_if.sv
// Carrier between the register side and the lock window counter.
// Assumes one clock domain.
`timescale 1ns/10ps
interface lock_detect_if;
	logic event_valid;
	logic [15:0] edge_diff;
	logic [15:0] lock_thr;
	logic [15:0] unlock_thr;
	logic [7:0] need_count;
	logic locked;
	logic [7:0] run_count;
	modport ctrl (output event_valid, edge_diff, lock_thr, unlock_thr, need_count,
		input locked, run_count);
	modport core (input event_valid, edge_diff, lock_thr, unlock_thr, need_count,
		output locked, run_count);
endinterface

// ===== core/lock_window_counter.sv
// Consecutive in-window counter with lock/unlock hysteresis.
// Assumes one phase-detector comparison event per event_valid pulse.
`timescale 1ns/10ps
module lock_window_counter (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	lock_detect_if.core lk
);
	import pll_lock_pkg::*;

	lock_state_t state;
	lock_state_t next_state;
	logic [7:0] next_count;

	wire in_lock_window = lk.edge_diff < lk.lock_thr; // [RULE5]
	wire past_unlock = lk.edge_diff > lk.unlock_thr; // [RULE6]
	wire count_done = (lk.run_count + 8'h01) >= lk.need_count;

	always_comb begin
		next_state = state;
		next_count = lk.run_count;
		if (lk.event_valid) begin
			unique case (state)
				LOCK_HUNT: begin
					if (!in_lock_window) begin
						next_count = 8'h00; // [RULE21]
					end else if (count_done) begin
						next_state = LOCK_HELD; // [RULE8]
						next_count = lk.need_count;
					end else begin
						next_count = lk.run_count + 8'h01; // [RULE8]
					end
				end
				LOCK_HELD: begin
					if (past_unlock) begin
						next_state = LOCK_HUNT; // [RULE9]
						next_count = 8'h00;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			state <= LOCK_HUNT;
			lk.run_count <= 8'h00;
		end else if (i_ce) begin
			state <= next_state;
			lk.run_count <= next_count;
		end
	end

	assign lk.locked = (state == LOCK_HELD);
endmodule // lock_window_counter

// ===== core/pll_lock_detect_logic.sv
// Lock indication of a clock-generator PLL: registers, divider settings, pin muxes.
// Assumes phase-detector events arrive as one-cycle pulses synchronous to i_sys_clk.
//
// Summary of operation
// RULE1: Reference and feedback divider delay cells each take a three-bit code.
// RULE2: Feedback count one bypasses B and A; divide equals prescaler value.
// RULE3: Dual-modulus feedback divide is prescaler times B plus A.
// RULE4: Digital lock indicator selectable onto lock, status and monitor pins.
// RULE5: A comparison is in-lock when edge difference is below lock threshold.
// RULE6: Unlock threshold is wider than lock threshold, giving hysteresis.
// RULE7: Window timing from range bit, antibacklash field and cycle count.
// RULE8: Lock declared after programmable run of consecutive in-lock comparisons.
// RULE9: Lock held until a single comparison exceeds the unlock threshold.
// RULE10: Software keeps comparison period longer than the unlock threshold.
// RULE11: N-channel analog mode idles high, pulses low.
// RULE12: P-channel analog mode idles low, pulses high.
// RULE13: Current-source mode sources while locked, shorts pin while unlocked.
// RULE14: Software selects current-source code and enables the pin comparator.
// RULE15: Pin comparator output selectable onto monitor or status pin.
// RULE16: Selected clock output enables pass only while charged lock is high.
// RULE17: Low-bandwidth loops should use a capacitor with current-source mode.
// RULE18: Clock input serves distribution only or external oscillator feedback.
// RULE19: Clock input also serves as feedback in external zero-delay mode.
// RULE20: Lock cycle select zero requires five consecutive in-lock comparisons.
// RULE21: In-lock run restarts on any out-of-window comparison before lock.
`timescale 1ns/10ps
`include "pll_lock_params.svh"
module pll_lock_detect_logic #(
	parameter int N_OUT = 16,
	parameter logic [15:0] LOCK_THR_HIGH = `LOCK_THR_HIGH_PS,
	parameter logic [15:0] UNLOCK_THR_HIGH = `UNLOCK_THR_HIGH_PS,
	parameter logic [15:0] LOCK_THR_LOW = `LOCK_THR_LOW_PS,
	parameter logic [15:0] UNLOCK_THR_LOW = `UNLOCK_THR_LOW_PS,
	parameter logic [15:0] ABP_STEP = `ABP_STEP_PS
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic [9:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_phase_detector_event,
	input wire logic [15:0] i_phase_detector_edge_diff,
	input wire logic i_phase_detector_pulse,
	input wire logic i_bias_resistor_double,
	input wire logic i_lock_detect_pin_level,
	input wire logic [N_OUT-1:0] i_out_enable,
	output logic [N_OUT-1:0] o_out_enable,
	output logic o_lock_detect_pin_out,
	output logic o_lock_detect_pin_oe_b,
	output logic o_lock_detect_isrc_en,
	output logic o_status_pin,
	output logic o_reference_monitor_pin,
	output logic o_digital_lock_indicator,
	output logic [2:0] o_ref_delay_code,
	output logic [2:0] o_fb_delay_code,
	output logic [18:0] o_fb_divide,
	output pll_lock_pkg::clk_in_mode_t o_clk_in_mode,
	output logic o_clk_in_to_dist,
	output logic o_clk_in_to_feedback
);
	import pll_lock_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register storage

	logic [7:0] fb_a_count;
	logic [7:0] fb_b_low;
	logic [7:0] fb_b_high;
	logic [7:0] prescaler_ctrl;
	logic [7:0] status_abp;
	logic [7:0] lock_cfg;
	logic [7:0] div_delay;
	logic [7:0] lp_pin_ctrl;
	logic [7:0] monpin_ctrl;
	logic [7:0] holdover_ctrl;
	logic [7:0] out_gate_lo;
	logic [7:0] out_gate_hi;
	logic [7:0] clk_in_ctrl;
	logic ack;

	////////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, answer on the second

	wire req = i_avs_read | i_avs_write;
	wire take = req & ~ack;
	wire wr_en = ack & i_avs_write & i_avs_byteenable[0];
	wire [7:0] wdat = i_avs_writedata[7:0];

	assign o_avs_waitrequest = req & ~ack;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			ack <= 1'b0;
		end else if (i_ce) begin
			ack <= take;
		end
	end

	wire sel_a = i_avs_address == `REG_FB_A_COUNT;
	wire sel_bl = i_avs_address == `REG_FB_B_LOW;
	wire sel_bh = i_avs_address == `REG_FB_B_HIGH;
	wire sel_pre = i_avs_address == `REG_PRESCALER;
	wire sel_st = i_avs_address == `REG_STATUS_ABP;
	wire sel_lk = i_avs_address == `REG_LOCK_CFG;
	wire sel_dly = i_avs_address == `REG_DIV_DELAY;
	wire sel_lp = i_avs_address == `REG_LP_PIN_CTRL;
	wire sel_rm = i_avs_address == `REG_MONPIN_CTRL;
	wire sel_ho = i_avs_address == `REG_HOLDOVER_CTRL;
	wire sel_gl = i_avs_address == `REG_OUT_GATE_LO;
	wire sel_gh = i_avs_address == `REG_OUT_GATE_HI;
	wire sel_ci = i_avs_address == `REG_CLK_IN_CTRL;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			fb_a_count <= `RST_REG8;
			fb_b_low <= `RST_B_LOW;
			fb_b_high <= `RST_REG8;
			prescaler_ctrl <= `RST_REG8;
			status_abp <= `RST_REG8;
			lock_cfg <= `RST_REG8;
			div_delay <= `RST_REG8;
			lp_pin_ctrl <= `RST_REG8;
			monpin_ctrl <= `RST_REG8;
			holdover_ctrl <= `RST_REG8;
			out_gate_lo <= `RST_REG8;
			out_gate_hi <= `RST_REG8;
			clk_in_ctrl <= `RST_REG8;
		end else if (i_ce && wr_en) begin
			if (sel_a) fb_a_count <= {2'b00, wdat[5:0]};
			if (sel_bl) fb_b_low <= wdat;
			if (sel_bh) fb_b_high <= {3'b000, wdat[4:0]};
			if (sel_pre) prescaler_ctrl <= {5'b00000, wdat[2:0]};
			if (sel_st) status_abp <= wdat;
			if (sel_lk) lock_cfg <= {1'b0, wdat[6:0]};
			if (sel_dly) div_delay <= wdat;
			if (sel_lp) lp_pin_ctrl <= {2'b00, wdat[5:0]};
			if (sel_rm) monpin_ctrl <= {3'b000, wdat[4:0]};
			if (sel_ho) holdover_ctrl <= wdat;
			if (sel_gl) out_gate_lo <= wdat;
			if (sel_gh) out_gate_hi <= wdat;
			if (sel_ci) clk_in_ctrl <= {6'b000000, wdat[1:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Feedback divider value

	function automatic logic [5:0] prescale_value(input logic [2:0] code);
		logic [5:0] v;
		v = 6'h01;
		unique case (code)
			3'h0: v = 6'h01;
			3'h1: v = 6'h02;
			3'h2: v = 6'h03;
			3'h3: v = 6'h02;
			3'h4: v = 6'h04;
			3'h5: v = 6'h08;
			3'h6: v = 6'h10;
			3'h7: v = 6'h20;
		endcase
		return v;
	endfunction

	wire [12:0] fb_b = {fb_b_high[4:0], fb_b_low};
	wire [5:0] pre_p = prescale_value(prescaler_ctrl[2:0]);
	wire dual_modulus_mode = prescaler_ctrl[2:0] >= `PRE_DM_FIRST;
	wire b_bypassed = fb_b == 13'h0001;
	wire [18:0] p_times_b = pre_p * fb_b;
	wire [18:0] dm_divide = p_times_b + {13'h0000, fb_a_count[5:0]}; // [RULE3]
	wire [18:0] next_fb_divide = b_bypassed ? {13'h0000, pre_p} : // [RULE2]
		(dual_modulus_mode ? dm_divide : p_times_b);

	////////////////////////////////////////////////////////////////////////////////
	// Lock window setup

	wire window_low = lock_cfg[`F_WINDOW];
	wire [1:0] abp_sel = status_abp[`F_ABP_HI:0];
	wire [1:0] cnt_sel = lock_cfg[`F_CNT_SEL_HI:`F_CNT_SEL_LO];
	wire [15:0] abp_extra = ABP_STEP * {14'h0000, abp_sel};
	wire [15:0] lock_base = window_low ? LOCK_THR_LOW : LOCK_THR_HIGH; // [RULE7]
	wire [15:0] unlock_base = window_low ? UNLOCK_THR_LOW : UNLOCK_THR_HIGH; // [RULE7]
	wire [15:0] lock_sum = lock_base + abp_extra;
	wire [15:0] unlock_sum = unlock_base + abp_extra; // [RULE6]
	wire [7:0] need_count = (cnt_sel == 2'b00) ? `LOCK_CYCLES_00 : // [RULE20]
		(cnt_sel == 2'b01) ? `LOCK_CYCLES_01 :
		(cnt_sel == 2'b10) ? `LOCK_CYCLES_10 : `LOCK_CYCLES_11; // [RULE8]

	lock_detect_if lk_bus ();

	assign lk_bus.event_valid = i_phase_detector_event;
	assign lk_bus.edge_diff = i_phase_detector_edge_diff;
	assign lk_bus.lock_thr = i_bias_resistor_double ? {lock_sum[14:0], 1'b0} : lock_sum;
	assign lk_bus.unlock_thr = i_bias_resistor_double ? {unlock_sum[14:0], 1'b0} : unlock_sum;
	assign lk_bus.need_count = need_count;

	lock_window_counter u_window (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.lk(lk_bus.core)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Lock-detect pin modes and comparator

	wire dli = lk_bus.locked & ~lock_cfg[`F_DLI_DISABLE];
	wire lp_cmp_en = holdover_ctrl[`F_LP_CMP_EN];
	wire charged_lock_detect = lp_cmp_en ? i_lock_detect_pin_level : 1'b1;
	wire [5:0] lp_code = lp_pin_ctrl[5:0];

	lp_mode_t lp_mode;
	assign lp_mode = (lp_code == `LP_CODE_DLI) ? LP_DLI :
		(lp_code == `LP_CODE_ALO_N) ? LP_ALO_N :
		(lp_code == `LP_CODE_ALO_P) ? LP_ALO_P :
		(lp_code == `LP_CODE_CHLK) ? LP_CHLK : LP_OFF;

	logic next_lp_out;
	logic next_lp_oe_b;
	logic next_isrc;

	always_comb begin
		next_lp_out = 1'b0;
		next_lp_oe_b = 1'b1;
		next_isrc = 1'b0;
		unique case (lp_mode)
			LP_OFF: begin
				next_lp_oe_b = 1'b1;
			end
			LP_DLI: begin
				next_lp_out = dli; // [RULE4]
				next_lp_oe_b = 1'b0;
			end
			LP_ALO_N: begin
				next_lp_oe_b = ~i_phase_detector_pulse; // [RULE11]
			end
			LP_ALO_P: begin
				next_lp_out = 1'b1;
				next_lp_oe_b = ~i_phase_detector_pulse; // [RULE12]
			end
			LP_CHLK: begin
				next_isrc = dli; // [RULE13]
				next_lp_oe_b = dli; // [RULE13]
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status and monitor pin muxes

	wire [5:0] status_sel = status_abp[7:`F_STATUS_SEL_LO];
	wire [5:0] monpin_sel = {1'b0, monpin_ctrl[4:0]};
	wire next_status = (status_sel == `PIN_SEL_DLI) ? dli : // [RULE4]
		(status_sel == `PIN_SEL_LP_CMP) & charged_lock_detect; // [RULE15]
	wire next_monpin = (monpin_sel == `PIN_SEL_DLI) ? dli : // [RULE4]
		(monpin_sel == `PIN_SEL_LP_CMP) & charged_lock_detect; // [RULE15]

	////////////////////////////////////////////////////////////////////////////////
	// Output enable gating, clock input routing

	wire [15:0] gate_bits = {out_gate_hi, out_gate_lo};

	genvar g;
	generate
		for (g = 0; g < N_OUT; g++) begin : g_gate
			assign o_out_enable[g] = i_out_enable[g] & (~gate_bits[g] | charged_lock_detect); // [RULE16]
		end
	endgenerate

	clk_in_mode_t clk_mode;
	assign clk_mode = (clk_in_ctrl[1:0] == 2'b01) ? CLK_IN_EXT_VCO :
		(clk_in_ctrl[1:0] == 2'b10) ? CLK_IN_ZERO_DELAY : CLK_IN_DIST;
	wire next_to_fb = (clk_mode == CLK_IN_EXT_VCO) | (clk_mode == CLK_IN_ZERO_DELAY); // [RULE18] [RULE19]

	////////////////////////////////////////////////////////////////////////////////
	// Registered outputs

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_lock_detect_pin_out <= 1'b0;
			o_lock_detect_pin_oe_b <= 1'b1;
			o_lock_detect_isrc_en <= 1'b0;
			o_status_pin <= 1'b0;
			o_reference_monitor_pin <= 1'b0;
			o_digital_lock_indicator <= 1'b0;
		end else if (i_ce) begin
			o_lock_detect_pin_out <= next_lp_out;
			o_lock_detect_pin_oe_b <= next_lp_oe_b;
			o_lock_detect_isrc_en <= next_isrc;
			o_status_pin <= next_status;
			o_reference_monitor_pin <= next_monpin;
			o_digital_lock_indicator <= dli;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_ref_delay_code <= 3'h0;
			o_fb_delay_code <= 3'h0;
			o_fb_divide <= 19'h0_0000;
			o_clk_in_mode <= CLK_IN_DIST;
			o_clk_in_to_dist <= 1'b1;
			o_clk_in_to_feedback <= 1'b0;
		end else if (i_ce) begin
			o_ref_delay_code <= div_delay[`F_REF_DELAY_LO+2:`F_REF_DELAY_LO]; // [RULE1]
			o_fb_delay_code <= div_delay[2:0]; // [RULE1]
			o_fb_divide <= next_fb_divide;
			o_clk_in_mode <= clk_mode;
			o_clk_in_to_dist <= 1'b1; // [RULE18]
			o_clk_in_to_feedback <= next_to_fb;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read-back

	function automatic logic [7:0] read_sel(input logic [9:0] a);
		logic [7:0] d;
		d = 8'h00;
		unique case (a)
			`REG_FB_A_COUNT: d = fb_a_count;
			`REG_FB_B_LOW: d = fb_b_low;
			`REG_FB_B_HIGH: d = fb_b_high;
			`REG_PRESCALER: d = prescaler_ctrl;
			`REG_STATUS_ABP: d = status_abp;
			`REG_LOCK_CFG: d = lock_cfg;
			`REG_DIV_DELAY: d = div_delay;
			`REG_LP_PIN_CTRL: d = lp_pin_ctrl;
			`REG_MONPIN_CTRL: d = monpin_ctrl;
			`REG_HOLDOVER_CTRL: d = holdover_ctrl;
			`REG_OUT_GATE_LO: d = out_gate_lo;
			`REG_OUT_GATE_HI: d = out_gate_hi;
			`REG_CLK_IN_CTRL: d = clk_in_ctrl;
			`REG_LOCK_STATUS: d = {5'b00000, next_isrc, charged_lock_detect, dli};
			`REG_RUN_COUNT: d = lk_bus.run_count;
			`REG_FB_N_0: d = o_fb_divide[7:0];
			`REG_FB_N_1: d = o_fb_divide[15:8];
			`REG_FB_N_2: d = {5'b00000, o_fb_divide[18:16]};
			default: d = 8'h00;
		endcase
		return d;
	endfunction

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_ce && take && i_avs_read) begin
			o_avs_readdata <= {24'h00_0000, read_sel(i_avs_address)};
		end
	end
endmodule // pll_lock_detect_logic

// ===== verif/lock_detect_asserts.sv
// Port checker for the lock-indication block.
// Assumes a bind to pll_lock_detect_logic and one clock domain.
`timescale 1ns/10ps
module lock_detect_asserts #(
	parameter int N_OUT = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic i_phase_detector_event,
	input wire logic [15:0] i_phase_detector_edge_diff,
	input wire logic i_lock_detect_pin_level,
	input wire logic [N_OUT-1:0] i_out_enable,
	input wire logic [N_OUT-1:0] o_out_enable,
	input wire logic o_lock_detect_pin_out,
	input wire logic o_lock_detect_pin_oe_b,
	input wire logic o_lock_detect_isrc_en,
	input wire logic o_digital_lock_indicator
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	////////////////////////////////////////////////////////////
	a_wait_first: assert property ((i_avs_read || i_avs_write) && !$past(i_avs_read)
		&& !$past(i_avs_write) |-> o_avs_waitrequest) else $error("new request not held off");
	a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest && i_ce
		|=> !o_avs_waitrequest) else $error("bus answer late");
	a_rdata_upper: assert property (o_avs_readdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_reset_idle: assert property ($rose(i_rst_b) |-> o_lock_detect_pin_oe_b
		&& !o_digital_lock_indicator && !o_lock_detect_isrc_en) else $error("pins not idle");
	a_lock_cause: assert property ($rose(o_digital_lock_indicator) |->
		$past(i_phase_detector_event, 2) || $past(i_avs_write) || $past(i_avs_write, 2))
		else $error("lock rose without comparison");
	a_drop_cause: assert property ($fell(o_digital_lock_indicator) |->
		$past(i_phase_detector_event, 2) || $past(i_avs_write) || $past(i_avs_write, 2))
		else $error("lock dropped without comparison");
	a_unlock_wide: assert property (i_ce && i_phase_detector_event
		&& i_phase_detector_edge_diff > 16'h3B60 |-> ##2 !o_digital_lock_indicator)
		else $error("lock kept after wide comparison");
	a_isrc_short: assert property (o_lock_detect_isrc_en |->
		o_lock_detect_pin_oe_b || o_lock_detect_pin_out) else $error("source and short together");
	a_gate_pass: assert property (i_lock_detect_pin_level |->
		o_out_enable == i_out_enable) else $error("output gated while charged");
	a_gate_mask: assert property ((o_out_enable & ~i_out_enable) == '0)
		else $error("output enabled without request");
	c_lock: cover property ($rose(o_digital_lock_indicator));
	c_charged: cover property (o_lock_detect_isrc_en && i_lock_detect_pin_level);
	c_write: cover property (i_avs_write && !o_avs_waitrequest);
endmodule // lock_detect_asserts
bind pll_lock_detect_logic lock_detect_asserts #(.N_OUT(N_OUT)) i_asserts (.i_sys_clk,
	.i_rst_b, .i_ce, .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
	.i_phase_detector_event, .i_phase_detector_edge_diff, .i_lock_detect_pin_level,
	.i_out_enable, .o_out_enable, .o_lock_detect_pin_out, .o_lock_detect_pin_oe_b,
	.o_lock_detect_isrc_en, .o_digital_lock_indicator);

// ===== verif/pd_model.sv
// Phase detector event source and lock pin capacitor model.
// Assumes commands from the bench just after a rising edge.
`timescale 1ns/10ps
module pd_model #(
	parameter int CAP_TRIP = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_go,
	input wire logic [15:0] i_diff,
	input wire logic [7:0] i_count,
	input wire logic i_pump,
	input wire logic i_isrc_en,
	input wire logic i_pin_oe_b,
	input wire logic i_pin_out,
	output logic o_event = 1'b0,
	output logic [15:0] o_edge_diff = 16'h0000,
	output logic o_pulse = 1'b0,
	output logic o_pin_level,
	output logic o_busy
);
	logic [7:0] left = 8'h00;
	logic [1:0] ph = 2'h0;
	logic [5:0] cap = 6'h00;
	wire logic fire = (left != 8'h00) && (ph == 2'h3);
	assign o_busy = (left != 8'h00) || o_event;
	// Driven pin wins, else capacitor at or above trip
	assign o_pin_level = (i_pin_oe_b === 1'b0) ? i_pin_out : (cap >= CAP_TRIP);
	always @(posedge i_sys_clk) begin
		// One comparison per four clocks, longer than any unlock window
		o_event <= fire;
		o_edge_diff <= fire ? i_diff : ~o_edge_diff;
		o_pulse <= i_pump;
		if (i_go) begin
			left <= i_count;
			ph <= 2'h0;
		end else if (left != 8'h00) begin
			ph <= ph + 2'h1;
			left <= fire ? left - 8'h01 : left;
		end
		if (i_pin_oe_b === 1'b0 && i_pin_out === 1'b0)
			cap <= 6'h00;
		else if (i_isrc_en === 1'b1 && cap != 6'h3F)
			cap <= cap + 6'h01;
	end
endmodule // pd_model

// ===== verif/tb.sv
// Self-checking bench of the lock-indication block.
// Assumes pd_model as the phase detector and lock pin load.
`timescale 1ns/10ps
module tb;
	import pll_lock_pkg::*;
	typedef struct packed {logic [7:0] p; logic [7:0] a; logic [15:0] b; logic [15:0] n;} row_t;
	row_t rows [11] = '{'{8'h00, 8'h00, 16'h0001, 16'h0001},
		'{8'h01, 8'h00, 16'h0001, 16'h0002}, '{8'h02, 8'h00, 16'h0001, 16'h0003},
		'{8'h01, 8'h05, 16'h0003, 16'h0006}, '{8'h03, 8'h00, 16'h0003, 16'h0006},
		'{8'h03, 8'h02, 16'h0003, 16'h0008}, '{8'h03, 8'h01, 16'h0004, 16'h0009},
		'{8'h04, 8'h01, 16'h0003, 16'h000D}, '{8'h07, 8'h09, 16'h0001, 16'h0020},
		'{8'h06, 8'h05, 16'h000A, 16'h00A5}, '{8'h03, 8'h00, 16'h0100, 16'h0200}};
	logic i_sys_clk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
	logic [9:0] i_avs_address = 10'h000;
	logic [31:0] i_avs_writedata = 32'h0000_0000, q, o_avs_readdata;
	logic i_bias_resistor_double = 1'b0, pd_go = 1'b0, pump = 1'b0, pd_busy;
	logic [15:0] i_out_enable = 16'h0000, pd_diff = 16'h0000, o_out_enable;
	logic [15:0] i_phase_detector_edge_diff;
	logic [7:0] pd_cnt = 8'h00;
	logic i_phase_detector_event, i_phase_detector_pulse, i_lock_detect_pin_level;
	logic o_avs_waitrequest, o_lock_detect_pin_out, o_lock_detect_pin_oe_b, o_lock_detect_isrc_en;
	logic o_status_pin, o_reference_monitor_pin, o_digital_lock_indicator;
	logic o_clk_in_to_dist, o_clk_in_to_feedback;
	logic [2:0] o_ref_delay_code, o_fb_delay_code;
	logic [18:0] o_fb_divide;
	clk_in_mode_t o_clk_in_mode;
	int num_errors = 0;
	int checks = 0;
	always #20 i_sys_clk = ~i_sys_clk;
	pll_lock_detect_logic i_dut (.i_sys_clk, .i_rst_b, .i_ce, .i_avs_address, .i_avs_read,
		.i_avs_write, .i_avs_writedata, .i_avs_byteenable(4'h1), .o_avs_readdata,
		.o_avs_waitrequest, .i_phase_detector_event, .i_phase_detector_edge_diff,
		.i_phase_detector_pulse, .i_bias_resistor_double, .i_lock_detect_pin_level,
		.i_out_enable, .o_out_enable, .o_lock_detect_pin_out, .o_lock_detect_pin_oe_b,
		.o_lock_detect_isrc_en, .o_status_pin, .o_reference_monitor_pin,
		.o_digital_lock_indicator, .o_ref_delay_code, .o_fb_delay_code, .o_fb_divide,
		.o_clk_in_mode, .o_clk_in_to_dist, .o_clk_in_to_feedback);
	pd_model i_pd (.i_sys_clk, .i_go(pd_go), .i_diff(pd_diff), .i_count(pd_cnt), .i_pump(pump),
		.i_isrc_en(o_lock_detect_isrc_en), .i_pin_oe_b(o_lock_detect_pin_oe_b),
		.i_pin_out(o_lock_detect_pin_out), .o_event(i_phase_detector_event),
		.o_edge_diff(i_phase_detector_edge_diff), .o_pulse(i_phase_detector_pulse),
		.o_pin_level(i_lock_detect_pin_level), .o_busy(pd_busy));
	////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (num_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		i_avs_address <= a;
		i_avs_writedata <= {24'h00_0000, d};
		i_avs_write <= w;
		i_avs_read <= !w;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			num_errors++;
			end_sim();
		end
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		@(posedge i_sys_clk);
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input string s, input logic [9:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(s, {24'h00_0000, e}, q);
	endtask
	// Run c comparisons with edge difference d, then let the indicator settle
	task automatic ev(input logic [15:0] d, input logic [7:0] c);
		int n;
		n = 0;
		pd_go <= 1'b1;
		pd_diff <= d;
		pd_cnt <= c;
		@(posedge i_sys_clk);
		pd_go <= 1'b0;
		@(posedge i_sys_clk);
		while (pd_busy !== 1'b0 && n < 2000) begin
			@(posedge i_sys_clk);
			n++;
		end
		if (n >= 2000) begin
			num_errors++;
			end_sim();
		end
		repeat (4) @(posedge i_sys_clk);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		chk("fb_divide_rst", 3, o_fb_divide);
		chk("pin_oe_b_rst", 1, o_lock_detect_pin_oe_b);
		rdc("b_low_rst", 10'h014, 8'h03);
		rdc("lock_cfg_rst", 10'h018, 8'h00);
		wr(10'h3FF, 8'hAA);
		rdc("unmapped", 10'h3FF, 8'h00);
		wr(10'h1F1, 8'h55);
		rdc("run_count_ro", 10'h1F1, 8'h00);
		foreach (rows[i]) begin
			wr(10'h016, rows[i].p);
			wr(10'h013, rows[i].a);
			wr(10'h014, rows[i].b[7:0]);
			wr(10'h015, rows[i].b[15:8]);
			repeat (2) @(posedge i_sys_clk);
			chk("fb_divide", rows[i].n, o_fb_divide);
			rdc("n_low", 10'h1F2, rows[i].n[7:0]);
		end
		wr(10'h019, 8'h2B);
		repeat (2) @(posedge i_sys_clk);
		chk("delays", 8'h2B, {o_ref_delay_code, o_fb_delay_code});
		for (int m = 0; m < 3; m++) begin
			wr(10'h1E0, 8'(m));
			repeat (2) @(posedge i_sys_clk);
			chk("clk_in", {m[1:0], 1'b1, m != 0},
				{o_clk_in_mode, o_clk_in_to_dist, o_clk_in_to_feedback});
		end
		ev(16'h0064, 4);
		ev(16'h0FA0, 1);
		rdc("run_restart", 10'h1F1, 8'h00);
		ev(16'h0DAB, 4);
		ev(16'h0DAC, 1);
		ev(16'h0DAB, 4);
		chk("dli_four", 0, o_digital_lock_indicator);
		ev(16'h0DAB, 1);
		chk("dli_five", 1, o_digital_lock_indicator);
		ev(16'h1B58, 1);
		chk("dli_hyst", 1, o_digital_lock_indicator);
		ev(16'h1B59, 1);
		chk("dli_drop", 0, o_digital_lock_indicator);
		wr(10'h018, 8'h10);
		wr(10'h017, 8'h05);
		ev(16'h02ED, 5);
		chk("status_lock", 1, o_status_pin);
		ev(16'h04B0, 1);
		chk("status_hold", 1, o_status_pin);
		ev(16'h04B1, 1);
		chk("status_drop", 0, o_status_pin);
		wr(10'h017, 8'h04);
		i_bias_resistor_double <= 1'b1;
		ev(16'h044B, 5);
		chk("dli_double", 1, o_digital_lock_indicator);
		ev(16'h4000, 1);
		chk("dli_wide", 0, o_digital_lock_indicator);
		i_bias_resistor_double <= 1'b0;
		wr(10'h018, 8'h30);
		ev(16'h01F4, 15);
		chk("dli_fifteen", 0, o_digital_lock_indicator);
		ev(16'h01F4, 1);
		chk("dli_sixteen", 1, o_digital_lock_indicator);
		i_out_enable <= 16'hFFFF;
		wr(10'h0FC, 8'h01);
		wr(10'h01D, 8'h08);
		wr(10'h01B, 8'h02);
		chk("gated", 16'hFFFE, o_out_enable);
		wr(10'h01A, 8'h04);
		repeat (30) @(posedge i_sys_clk);
		chk("charged_pass", 16'hFFFF, o_out_enable);
		chk("reference_monitor_pin_cmp", 1, o_reference_monitor_pin);
		rdc("lock_status", 10'h1F0, 8'h07);
		ev(16'h03E9, 1);
		chk("pin_short", 3'b000, {o_lock_detect_isrc_en, o_lock_detect_pin_oe_b,
			o_lock_detect_pin_out});
		chk("regated", 16'hFFFE, o_out_enable);
		chk("reference_monitor_pin_low", 0, o_reference_monitor_pin);
		for (int m = 1; m < 4; m++) begin
			wr(10'h01A, 8'(m));
			pump <= 1'b1;
			repeat (4) @(posedge i_sys_clk);
			chk("pin_pulse", {1'b0, m == 3}, {o_lock_detect_pin_oe_b,
				o_lock_detect_pin_out});
			pump <= 1'b0;
			repeat (4) @(posedge i_sys_clk);
			chk("pin_idle", m != 1, o_lock_detect_pin_oe_b);
		end
		end_sim();
	end
endmodule // tb
